/* File: src/sbst_tap.sv */
// Boundary-scan test access port of the dual-port memory.
// Function
// [R1] Sample on test-clock rise, drive on fall.
// [R2] Select and data pins default high.
// [R3] Shift in at MSB, out at LSB.
// [R4] Five high select edges reset controller.
// [R5] Test reset leaves memory operation alone.
// [R6] Power-up reset leaves data output high-impedance.
// [R7] Instruction selects exactly one data register.
// [R8] Three-bit instruction, five codes, three reserved.
// [R9] Reset loads identification-read instruction.
// [R10] Instruction capture loads pattern 01.
// [R11] One-bit skip register cleared under bypass.
// [R12] Data capture loads whole pin ring.
// [R13] Extest and both sample instructions capture ring.
// [R14] Identification instruction captures 32-bit value.
// [R15] New instruction applied only at update.
// [R16] Sample-with-Z floats output bus until replaced.
// [R17] Data output driven only while shifting.
// [R18] Extest drives preloaded values onto outputs.
// [R19] Cell 108 enables output bus under extest.
// [R20] Standard sixteen-state controller on select.
// [R21] Reserved codes behave as bypass.
`timescale 1ns/10ps
`include "sbst_defs.svh"
module sbst_tap
    import sbst_pkg::*;
#(
    parameter int                    BSR_LEN = `SBST_BSR_LEN,
    // Identity value is arbitrary.
    parameter logic [`SBST_ID_W-1:0] ID_CODE = `SBST_ID_VALUE
)
(
    // Clock and reset
    input  wire logic               CORE_CLK,
    input  wire logic               RESETN,
    // Serial test pins
    input  wire logic               TCK,
    input  wire logic               TMS,
    input  wire logic               TDI,
    output logic                    TDO,
    output logic                    TDO_OE,
    // Pin ring
    input  wire logic [BSR_LEN-1:0] RING_IN,
    output logic [BSR_LEN-1:0]      RING_OUT,
    output logic                    EXTEST_ACTIVE,
    output logic                    QBUS_OE
);

    // ======================================================================
    // Types and state
    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_ID     = 2'h1,
        SEL_BSR    = 2'h2
    } sbst_sel_t;

    typedef struct packed {
        sbst_state_t          state;
        logic [2:0]           ir_sh;
        logic [2:0]           test_instruction;
        logic                 one_bit_skip;
        logic [`SBST_ID_W-1:0] part_identity;
        sbst_dout_t           dout;
        logic [BSR_LEN-1:0]   ring_out;
        logic                 extest;
        logic                 qbus_oe;
    } sbst_st_t;

    sbst_st_t st_reg;
    sbst_st_t st_next;

    sbst_pins_t         pins_raw;
    sbst_pins_t         pins;
    logic               tck_rise;
    logic               tck_fall;
    logic [BSR_LEN-1:0] bsr_q;
    logic [BSR_LEN-1:0] bsr_upd;
    logic               bsr_cap;
    logic               bsr_sh;
    logic               bsr_up;
    logic               in_reset;
    sbst_sel_t          sel;

    // ======================================================================
    // Functions
    function automatic sbst_state_t next_state(input sbst_state_t s, input logic m);
        sbst_state_t n;
        n = s;
        case (s) // [R20]
            ST_RESET:  n = m ? ST_RESET  : ST_IDLE; // [R4]
            ST_IDLE:   n = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR:  n = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: n = m ? ST_UPD_DR : ST_PAU_DR;
            ST_PAU_DR: n = m ? ST_EX2_DR : ST_PAU_DR;
            ST_EX2_DR: n = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: n = m ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR: n = m ? ST_RESET  : ST_CAP_IR;
            ST_CAP_IR: n = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR:  n = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: n = m ? ST_UPD_IR : ST_PAU_IR;
            ST_PAU_IR: n = m ? ST_EX2_IR : ST_PAU_IR;
            ST_EX2_IR: n = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: n = m ? ST_SEL_DR : ST_IDLE;
            default:   n = ST_RESET;
        endcase
        return n;
    endfunction

    // Reserved codes fall through to the skip register.
    function automatic sbst_sel_t decode_sel(input logic [2:0] ins);
        sbst_sel_t r;
        case (ins) // [R7]
            `SBST_INS_IDCODE:  r = SEL_ID;
            `SBST_INS_EXTEST,
            `SBST_INS_SAMPLE,
            `SBST_INS_SAMPLEZ: r = SEL_BSR; // [R13]
            default:           r = SEL_BYPASS; // [R21] [R8]
        endcase
        return r;
    endfunction

    // ======================================================================
    // Pin synchroniser and boundary register
    assign pins_raw = '{tck: TCK, tms: TMS, tdi: TDI};

    sbst_sync u_sync (
        .clk      (CORE_CLK),
        .rst_n    (RESETN),
        .pins_in  (pins_raw),
        .pins_out (pins),
        .tck_rise (tck_rise),
        .tck_fall (tck_fall)
    );

    assign sel      = decode_sel(st_reg.test_instruction);
    assign in_reset = (st_reg.state == ST_RESET);
    assign bsr_cap  = tck_rise && st_reg.state == ST_CAP_DR && sel == SEL_BSR; // [R13]
    assign bsr_sh   = tck_rise && st_reg.state == ST_SH_DR && sel == SEL_BSR; // [R1]
    assign bsr_up   = tck_rise && st_reg.state == ST_UPD_DR && sel == SEL_BSR;

    sbst_bsr #(
        .LEN (BSR_LEN)
    ) u_bsr (
        .clk       (CORE_CLK),
        .rst_n     (RESETN),
        .capture   (bsr_cap),
        .shift     (bsr_sh),
        .update    (bsr_up),
        .clear_upd (in_reset),
        .sin       (pins.tdi),
        .ring      (RING_IN),
        .shift_q   (bsr_q),
        .upd_q     (bsr_upd)
    );

    // ======================================================================
    // Controller and serial registers
    // Controller state lives here, boundary-register state in u_bsr, neither in the memory datapath, so a test reset
    // never touches memory operation. [R5]
    always_comb begin
        st_next = st_reg;
        if (tck_rise) begin // [R1]
            st_next.state = next_state(st_reg.state, pins.tms);
            case (st_reg.state)
                ST_CAP_IR: begin
                    st_next.ir_sh = {1'h0, `SBST_IR_CAPTURE}; // [R10]
                end
                ST_SH_IR: begin
                    st_next.ir_sh = {pins.tdi, st_reg.ir_sh[2:1]}; // [R3]
                end
                ST_UPD_IR: begin
                    st_next.test_instruction = st_reg.ir_sh; // [R15]
                end
                ST_CAP_DR: begin
                    if (sel == SEL_ID) begin
                        st_next.part_identity = ID_CODE; // [R14]
                    end else if (sel == SEL_BYPASS) begin
                        st_next.one_bit_skip = 1'h0; // [R11]
                    end
                end
                ST_SH_DR: begin
                    if (sel == SEL_ID) begin
                        st_next.part_identity = {pins.tdi, st_reg.part_identity[31:1]};
                    end else if (sel == SEL_BYPASS) begin
                        st_next.one_bit_skip = pins.tdi;
                    end
                end
                default: begin
                end
            endcase
        end
        if (tck_fall) begin // [R1]
            st_next.dout.tdo_oe = (st_reg.state == ST_SH_DR) || (st_reg.state == ST_SH_IR); // [R17]
            if (st_reg.state == ST_SH_IR) begin
                st_next.dout.tdo = st_reg.ir_sh[0]; // [R3]
            end else begin
                case (sel)
                    SEL_ID:  st_next.dout.tdo = st_reg.part_identity[0];
                    SEL_BSR: st_next.dout.tdo = bsr_q[0];
                    default: st_next.dout.tdo = st_reg.one_bit_skip;
                endcase
            end
            if (!st_next.dout.tdo_oe) begin
                st_next.dout.tdo = 1'h0;
            end
        end
        // Held for as long as the reset state lasts, so a test clock that stops
        // right after the fifth high select edge still leaves no old instruction.
        if (in_reset) begin
            st_next.test_instruction = `SBST_INS_IDCODE; // [R9]
        end
        st_next.extest   = (st_reg.test_instruction == `SBST_INS_EXTEST); // [R18]
        st_next.ring_out = bsr_upd; // [R18]
        case (st_reg.test_instruction)
            `SBST_INS_SAMPLEZ: st_next.qbus_oe = 1'h0; // [R16]
            `SBST_INS_EXTEST:  st_next.qbus_oe = bsr_upd[`SBST_BSR_OE_BIT]; // [R19]
            default:           st_next.qbus_oe = 1'h1;
        endcase
    end

    // Power-up lands in the reset state with the output floating. [R6]
    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_reg                  <= '0;
            st_reg.state            <= ST_RESET;
            st_reg.test_instruction <= `SBST_INS_IDCODE; // [R9]
            st_reg.qbus_oe          <= 1'h1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ======================================================================
    // Outputs
    assign TDO           = st_reg.dout.tdo;
    assign TDO_OE        = st_reg.dout.tdo_oe;
    assign RING_OUT      = st_reg.ring_out;
    assign EXTEST_ACTIVE = st_reg.extest;
    assign QBUS_OE       = st_reg.qbus_oe;

endmodule

/* File: src/sbst_defs.svh */
// Constants for the memory boundary-scan test port.
`ifndef SBST_DEFS_SVH
`define SBST_DEFS_SVH

// ==========================================================================
// Instruction codes
`define SBST_IR_W          3
`define SBST_INS_EXTEST    3'h0
`define SBST_INS_IDCODE    3'h1
`define SBST_INS_SAMPLEZ   3'h2
`define SBST_INS_SAMPLE    3'h3
`define SBST_INS_BYPASS    3'h7
`define SBST_IR_CAPTURE    2'h1

// ==========================================================================
// Register sizes and positions
`define SBST_ID_W          32
`define SBST_ID_VALUE      32'h0ABC_D001
`define SBST_BSR_LEN       109
`define SBST_BSR_OE_BIT    108
`define SBST_RESET_EDGES   5

`endif

/* File: src/sbst_pkg.sv */
// Types shared by the boundary-scan test port files.
package sbst_pkg;

    // ======================================================================
    // Controller states
    typedef enum logic [3:0] {
        ST_RESET   = 4'h0,
        ST_IDLE    = 4'h1,
        ST_SEL_DR  = 4'h2,
        ST_CAP_DR  = 4'h3,
        ST_SH_DR   = 4'h4,
        ST_EX1_DR  = 4'h5,
        ST_PAU_DR  = 4'h6,
        ST_EX2_DR  = 4'h7,
        ST_UPD_DR  = 4'h8,
        ST_SEL_IR  = 4'h9,
        ST_CAP_IR  = 4'hA,
        ST_SH_IR   = 4'hB,
        ST_EX1_IR  = 4'hC,
        ST_PAU_IR  = 4'hD,
        ST_EX2_IR  = 4'hE,
        ST_UPD_IR  = 4'hF
    } sbst_state_t;

    // ======================================================================
    // Serial pins after synchronisation
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sbst_pins_t;

    // ======================================================================
    // Serial data output with its enable
    typedef struct packed {
        logic tdo;
        logic tdo_oe;
    } sbst_dout_t;

endpackage

/* File: src/sbst_sync.sv */
// Two-stage synchroniser and edge finder for the serial test pins.
`timescale 1ns/10ps
module sbst_sync
    import sbst_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Raw and synchronised pins
    input  wire sbst_pins_t pins_in,
    output sbst_pins_t      pins_out,
    output logic            tck_rise,
    output logic            tck_fall
);

    typedef struct packed {
        sbst_pins_t s1;
        sbst_pins_t s2;
        logic       tck_d;
    } sbst_sync_st_t;

    sbst_sync_st_t st_reg;
    sbst_sync_st_t st_next;

    // Undriven select and data pins idle high, so reset values are ones.
    always_comb begin
        st_next       = st_reg;
        st_next.s1    = pins_in;
        st_next.s2    = st_reg.s1;
        st_next.tck_d = st_reg.s2.tck;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '{s1: 3'h3, s2: 3'h3, tck_d: 1'h0}; // [R2]
        end else begin
            st_reg <= st_next;
        end
    end

    assign pins_out = st_reg.s2;
    assign tck_rise = st_reg.s2.tck & ~st_reg.tck_d;
    assign tck_fall = ~st_reg.s2.tck & st_reg.tck_d;

endmodule

/* File: src/sbst_bsr.sv */
// Boundary-scan register: shift stage plus update latch for the pin ring.
`timescale 1ns/10ps
`include "sbst_defs.svh"
module sbst_bsr
    import sbst_pkg::*;
#(
    parameter int LEN = `SBST_BSR_LEN
)
(
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // Control from the controller
    input  wire logic           capture,
    input  wire logic           shift,
    input  wire logic           update,
    input  wire logic           clear_upd,
    input  wire logic           sin,
    input  wire logic [LEN-1:0] ring,
    // Results
    output logic [LEN-1:0]      shift_q,
    output logic [LEN-1:0]      upd_q
);

    typedef struct packed {
        logic [LEN-1:0] sh;
        logic [LEN-1:0] up;
    } sbst_bsr_st_t;

    sbst_bsr_st_t st_reg;
    sbst_bsr_st_t st_next;

    always_comb begin
        st_next = st_reg;
        if (capture) begin
            st_next.sh = ring; // [R12]
        end else if (shift) begin
            st_next.sh = {sin, st_reg.sh[LEN-1:1]}; // [R3]
        end
        if (clear_upd) begin
            st_next.up = '0;
        end else if (update) begin
            st_next.up = st_reg.sh;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign shift_q = st_reg.sh;
    assign upd_q   = st_reg.up;

endmodule

/* File: tb/sbst_tap_chk.sv */
// Port checks for the boundary-scan test port.
`timescale 1ns/10ps
module sbst_tap_chk #(
    parameter int BSR_LEN = 109
)
(
    // Clock and reset
    input wire logic               CORE_CLK,
    input wire logic               RESETN,
    // Serial test pins
    input wire logic               TCK,
    input wire logic               TMS,
    input wire logic               TDI,
    input wire logic               TDO,
    input wire logic               TDO_OE,
    // Pin ring
    input wire logic [BSR_LEN-1:0] RING_IN,
    input wire logic [BSR_LEN-1:0] RING_OUT,
    input wire logic               EXTEST_ACTIVE,
    input wire logic               QBUS_OE
);
    // ==================================================================
    // Assertions
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    a_reset_quiet: assert property ($rose(RESETN) |-> !TDO_OE && QBUS_OE && !EXTEST_ACTIVE)
        else $error("outputs not idle after reset");
    a_tdo_quiet: assert property (!TDO_OE |-> !TDO)
        else $error("serial output not low while disabled");
    // The synchroniser delays a pin fall by about three cycles.
    a_out_on_fall: assert property ($changed({TDO, TDO_OE}) |-> !$past(TCK, 2))
        else $error("serial output moved outside a clock fall");
    a_out_hold_hi: assert property (TCK && $past(TCK) |-> $stable({TDO, TDO_OE}))
        else $error("serial output moved while test clock high");
    a_mode_on_rise: assert property ($changed(EXTEST_ACTIVE) |-> $past(TCK, 2))
        else $error("instruction applied outside a clock rise");
    a_qbus_on_rise: assert property ($changed(QBUS_OE) |-> $past(TCK, 2))
        else $error("bus enable moved outside a clock rise");
    a_ring_on_rise: assert property ($changed(RING_OUT) |-> $past(TCK, 2))
        else $error("ring outputs moved outside a clock rise");
    a_cell_enables: assert property (EXTEST_ACTIVE && $past(EXTEST_ACTIVE, 2)
        && RING_OUT == $past(RING_OUT, 2) |-> QBUS_OE == RING_OUT[108])
        else $error("bus enable does not follow the enable cell");
endmodule

bind sbst_tap sbst_tap_chk #(.BSR_LEN(BSR_LEN)) sbst_tap_chk_i (
    .CORE_CLK(CORE_CLK), .RESETN(RESETN), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TDO(TDO), .TDO_OE(TDO_OE), .RING_IN(RING_IN), .RING_OUT(RING_OUT),
    .EXTEST_ACTIVE(EXTEST_ACTIVE), .QBUS_OE(QBUS_OE)
);

/* File: tb/sbst_host.sv */
// Model of the external boundary-scan controller on the serial pins.
`timescale 1ns/10ps
module sbst_host (
    // Serial pins
    input  wire logic TDO,
    output logic      TCK,
    output logic      TMS,
    output logic      TDI
);
    // ==================================================================
    // Pin driving
    initial begin
        TCK = 1'b0;
        TMS = 1'b1;
        TDI = 1'b1;
    end

    // One test-clock period of 125 ns, free of the core clock. TDO is taken at
    // the rise, a full half period after the fall that launched it.
    task automatic step(input logic m, input logic d, output logic o);
        TCK <= 1'b0;
        TMS <= m;
        TDI <= d;
        #62.5;
        TCK <= 1'b1;
        o = TDO;
        #62.5;
    endtask

    // Leaves the port in its reset state with the test clock stopped high.
    task automatic reset_tap();
        logic o;
        repeat (5) step(1'b1, 1'b1, o);
    endtask

    // From idle: capture, shift n bits LSB first, update, back to idle.
    task automatic scan(input logic ir, input int n, input logic [127:0] din,
                        output logic [127:0] dout);
        logic o;
        dout = '0;
        step(1'b1, 1'b1, o);
        if (ir) step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
        step(1'b0, 1'b1, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'b1, 1'b1, o);
        step(1'b0, 1'b1, o);
    endtask
endmodule

/* File: tb/sbst_tap_tb.sv */
// Self-checking bench for the boundary-scan test port.
`timescale 1ns/10ps
`include "sbst_defs.svh"
module sbst_tap_tb;
    localparam int N = `SBST_BSR_LEN;
    logic         CORE_CLK, RESETN, TCK, TMS, TDI, TDO, TDO_OE, EXTEST_ACTIVE, QBUS_OE, o;
    logic [N-1:0] RING_IN, RING_OUT;
    logic [127:0] d, q, pat;
    logic [2:0]   skip_codes [4] = '{`SBST_INS_BYPASS, 3'h4, 3'h5, 3'h6};
    logic [2:0]   ring_codes [3] = '{`SBST_INS_SAMPLE, `SBST_INS_EXTEST, `SBST_INS_SAMPLEZ};
    int           failures, checks, cyc;

    // ==================================================================
    // Design, controller model, clock and helpers
    sbst_tap sbst_tap_i (.CORE_CLK(CORE_CLK), .RESETN(RESETN), .TCK(TCK), .TMS(TMS),
        .TDI(TDI), .TDO(TDO), .TDO_OE(TDO_OE), .RING_IN(RING_IN), .RING_OUT(RING_OUT),
        .EXTEST_ACTIVE(EXTEST_ACTIVE), .QBUS_OE(QBUS_OE));
    sbst_host sbst_host_i (.TDO(TDO), .TCK(TCK), .TMS(TMS), .TDI(TDI));

    initial begin
        CORE_CLK = 1'b0;
        forever #5 CORE_CLK = ~CORE_CLK;
    end

    function automatic logic [127:0] rnd();
        return {$urandom, $urandom, $urandom, $urandom};
    endfunction

    // One-stage skip path modelled as a queue preloaded with its captured zero.
    function automatic logic [127:0] skip_model(input logic [127:0] din, input int n);
        logic [127:0] r = '0;
        logic         fifo[$] = {1'b0};
        for (int i = 0; i < n; i++) begin
            fifo.push_back(din[i]);
            r[i] = fifo.pop_front();
        end
        return r;
    endfunction

    task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s", $time, what);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Roughly 7200 cycles are needed; the ceiling leaves wide margin.
    always @(posedge CORE_CLK) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            report_and_stop();
        end
    end

    // ==================================================================
    // Scenarios
    initial begin
        RESETN   = 1'b0;
        RING_IN  = '0;
        failures = 0;
        checks   = 0;
        cyc      = 0;
        void'($urandom(32'h834E));
        repeat (16) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        repeat (4) @(posedge CORE_CLK);
        chk({TDO_OE, QBUS_OE, EXTEST_ACTIVE}, 3'b010, "outputs after reset");
        sbst_host_i.step(1'b0, 1'b1, o);
        sbst_host_i.scan(1'b0, 32, rnd(), q);
        chk(q[31:0], `SBST_ID_VALUE, "identity read");
        foreach (skip_codes[k]) begin
            sbst_host_i.scan(1'b1, 3, skip_codes[k], q);
            chk(q[1:0], `SBST_IR_CAPTURE, "instruction capture");
            d = rnd();
            sbst_host_i.scan(1'b0, 16, d, q);
            chk(q[15:0], skip_model(d, 16), "skip path");
        end
        foreach (ring_codes[k]) begin
            d = rnd();
            @(posedge CORE_CLK);
            RING_IN <= d[N-1:0];
            sbst_host_i.scan(1'b1, 3, ring_codes[k], q);
            pat = rnd();
            sbst_host_i.scan(1'b0, N, pat, q);
            chk(q[N-1:0], RING_IN, "ring capture");
            chk(RING_OUT, pat[N-1:0], "ring update");
            chk({EXTEST_ACTIVE, QBUS_OE}, {ring_codes[k] == 0, ring_codes[k] == 0 ?
                pat[`SBST_BSR_OE_BIT] : ring_codes[k] != `SBST_INS_SAMPLEZ}, "bus enable");
        end
        sbst_host_i.step(1'b1, 1'b1, o);
        sbst_host_i.step(1'b0, 1'b1, o);
        sbst_host_i.step(1'b0, 1'b1, o);
        sbst_host_i.reset_tap();
        chk({EXTEST_ACTIVE, QBUS_OE}, 2'b01, "bus after port reset");
        sbst_host_i.step(1'b0, 1'b1, o);
        sbst_host_i.scan(1'b0, 32, '0, q);
        chk(q[31:0], `SBST_ID_VALUE, "identity after port reset");
        report_and_stop();
    end
endmodule
